// File: design/pwr_pkg.sv
// Shared constants and types for the power-mode and power-on reset controller
package pwr_pkg;
	localparam logic [11:0] off_power_control = 12'h000;
	localparam logic [11:0] off_clock_control = 12'h004;
	localparam logic [11:0] off_status = 12'h008;
	localparam logic [11:0] off_wake_cause = 12'h00c;
	// Power control fields
	localparam int power_control_reg_mode_lsb = 0;
	localparam int power_control_reg_serial_wake_bit = 2;
	localparam int power_control_reg_ext_int_wake_bit = 3;
	// Clock control fields
	localparam int ccon_osc_pd_bit = 0;
	localparam logic [31:0] power_control_reset = 32'h0000_0000;
	localparam logic [31:0] clock_control_reset = 32'h0000_0000;
	// Timing
	localparam int clk_mhz = 125;
	localparam int por_delay_ms = 128;
	localparam longint por_delay_cycles = longint'(por_delay_ms) * 1000 * clk_mhz;
	localparam int pll_lock_cycles = 16;
	typedef enum logic [1:0] {
		mode_normal = 2'b00,
		mode_idle = 2'b01,
		mode_power_down = 2'b10
	} mode_t;
	typedef struct packed {
		logic time_interval_counter;
		logic serial;
		logic external_interrupt_zero;
		logic other;
	} wake_src_t;
endpackage : pwr_pkg

// File: design/power_mode_wake_por_control.sv
// Power-mode, wake-up and power-on reset sequencer with an APB register slave
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - Software writes a mode field to enter idle or full power-down.
// - Idle stops the PLL-derived core clock, oscillator keeps running.
// - Idle keeps peripheral clocks running.
// - Idle keeps core registers; only the core clock is gated, no reset.
// - Idle holds port and converter output pins unchanged.
// - Idle ends on any enabled interrupt or hardware reset.
// - Power-down stops both PLL and core clock.
// - Power-down halts the oscillator if the oscillator power-down bit is set.
// - Power-down keeps the interval counter clock unless the oscillator power-down bit is set, other peripherals off.
// - Power-down holds port levels and three-states the converter output.
// - Reset pin in power-down returns to normal with default registers.
// - Power cycling loads defaults and releases core after about 128 ms.
// - Interval counter interrupt ends power-down and is serviced.
// - Serial interrupt wakes from power-down only if serial wake enabled.
// - External interrupt zero wakes only if its wake enable is set.
// - Reset held below 2.45 V, then released after a 128 ms timer.
// - Falling supply keeps reset released until below 1 V.
module power_mode_wake_por_control #(
	parameter longint por_delay = pwr_pkg::por_delay_cycles
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_above_high,
	input wire logic supply_above_low,
	input wire pwr_pkg::wake_src_t irq_pending,
	input wire logic irq_serviced,
	input wire logic pll_locked,
	output logic core_reset_n,
	output logic core_clk_en,
	output logic pll_en,
	output logic osc_en,
	output logic periph_clk_en,
	output logic tic_clk_en,
	output logic pins_hold,
	output logic dac_out_oe,
	output logic wake_irq_take
);
	import pwr_pkg::*;

	mode_t mode_reg;
	logic [31:0] power_control_reg;
	logic [31:0] clock_control_reg;
	wake_src_t wake_cause_reg;
	logic por_hold_reg;
	logic [31:0] por_cnt_reg;
	logic [4:0] lock_cnt_reg;
	logic waking_reg;
	logic por_active;
	logic wr_access;
	logic rd_access;
	logic serial_wake_enable;
	logic ext_int_wake_enable;
	logic pd_wake;
	logic idle_wake;
	mode_t req_mode;
	mode_t mode_next;
	wake_src_t wake_cause_next;
	logic in_normal;
	logic in_idle;
	logic in_power_down;
	logic tic_wake;
	logic serial_wake;
	logic ext_int_wake;
	logic setup_phase;
	logic sel_power_control;
	logic sel_clock_control;
	logic sel_status;
	logic sel_wake_cause;
	logic addr_mapped;
	logic por_done;
	logic lock_done;
	logic osc_stop;
	logic [31:0] power_control_view;
	logic [31:0] status_word;
	// Counter end points, sized once so the compares stay narrow
	localparam logic [31:0] por_last = 32'(por_delay - 1);
	localparam logic [4:0] lock_last = 5'(pll_lock_cycles - 1);

	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && penable && !pwrite;
	assign serial_wake_enable = power_control_reg[power_control_reg_serial_wake_bit];
	assign ext_int_wake_enable = power_control_reg[power_control_reg_ext_int_wake_bit];
	assign req_mode = mode_t'(pwdata[power_control_reg_mode_lsb +: 2]);
	assign in_normal = mode_reg == mode_normal;
	assign in_idle = mode_reg == mode_idle;
	assign in_power_down = mode_reg == mode_power_down;

	// Address decode shared by writes and the error answer; reads decode paddr in their own case
	assign setup_phase = psel && !penable;
	assign sel_power_control = paddr == off_power_control;
	assign sel_clock_control = paddr == off_clock_control;
	assign sel_status = paddr == off_status;
	assign sel_wake_cause = paddr == off_wake_cause;
	assign addr_mapped = sel_power_control || sel_clock_control || sel_status || sel_wake_cause;
	assign power_control_view = power_control_reg | {30'h0, mode_reg};
	assign status_word = {28'h0000000, pll_locked, waking_reg, mode_reg};

	// Oscillator and interval counter stop together; the counter runs from it
	assign osc_stop = in_power_down && clock_control_reg[ccon_osc_pd_bit];
	assign por_done = por_cnt_reg >= por_last;
	assign lock_done = pll_locked && lock_cnt_reg >= lock_last;

	// Hysteresis: asserted below the high threshold only from power-up side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_hold_reg <= 1'b1;
		end else if (!supply_above_low) begin
			por_hold_reg <= 1'b1;
		end else if (supply_above_high && por_done) begin
			por_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_cnt_reg <= 32'h0000_0000;
		end else if (!supply_above_high || !por_hold_reg) begin
			por_cnt_reg <= 32'h0000_0000;
		end else begin
			por_cnt_reg <= por_cnt_reg + 32'd1;
		end
	end

	assign por_active = por_hold_reg;

	// Wake from power-down: interval counter always, serial and external interrupt zero gated by enables, other never
	assign tic_wake = irq_pending.time_interval_counter;
	assign serial_wake = irq_pending.serial && serial_wake_enable;
	assign ext_int_wake = irq_pending.external_interrupt_zero && ext_int_wake_enable;
	assign pd_wake = tic_wake || serial_wake || ext_int_wake;
	assign idle_wake = |irq_pending;

	// Mode next value: reset and wake take priority over a software request
	always_comb begin
		mode_next = mode_reg;
		if (por_active) begin
			mode_next = mode_normal;
		end else if (in_idle && idle_wake) begin
			mode_next = mode_normal;
		end else if (in_power_down && pd_wake) begin
			mode_next = mode_normal;
		end else if (wr_access && sel_power_control && in_normal) begin
			if (req_mode == mode_idle || req_mode == mode_power_down) begin
				mode_next = req_mode;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= mode_normal;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Core waits for PLL relock after power-down before servicing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waking_reg <= 1'b0;
		end else if (por_active) begin
			waking_reg <= 1'b0;
		end else if (in_power_down && pd_wake) begin
			waking_reg <= 1'b1;
		end else if (waking_reg && lock_done) begin
			waking_reg <= 1'b0;
		end
	end

	// Relock wait restarts on every wake and saturates at its end point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_cnt_reg <= 5'd0;
		end else if (por_active || !waking_reg) begin
			lock_cnt_reg <= 5'd0;
		end else if (lock_cnt_reg < lock_last) begin
			lock_cnt_reg <= lock_cnt_reg + 5'd1;
		end
	end

	// Registers return to defaults on any power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_control_reg <= power_control_reset;
		end else if (por_active) begin
			power_control_reg <= power_control_reset;
		end else if (wr_access && sel_power_control) begin
			power_control_reg <= {28'h0000000, pwdata[power_control_reg_ext_int_wake_bit], pwdata[power_control_reg_serial_wake_bit], 2'b00};
		end
	end

	// Oscillator power-down choice only acts once power-down is entered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_control_reg <= clock_control_reset;
		end else if (por_active) begin
			clock_control_reg <= clock_control_reset;
		end else if (wr_access && sel_clock_control) begin
			clock_control_reg <= {31'h00000000, pwdata[ccon_osc_pd_bit]};
		end
	end

	// Cause is sticky; a new wake wins over a clear in the same cycle
	always_comb begin
		wake_cause_next = wake_cause_reg;
		if (por_active) begin
			wake_cause_next = '0;
		end else if (in_power_down && pd_wake) begin
			wake_cause_next = irq_pending;
		end else if (wr_access && sel_wake_cause) begin
			wake_cause_next = wake_cause_reg & ~wake_src_t'(pwdata[3:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cause_reg <= '0;
		end else begin
			wake_cause_reg <= wake_cause_next;
		end
	end

	// Clock and pin controls, one registered output per concern
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_n <= 1'b0;
		end else begin
			core_reset_n <= !por_active;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_en <= 1'b0;
		end else begin
			pll_en <= !in_power_down;
		end
	end

	// Core clock waits for relock so the first serviced cycle is clean
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_clk_en <= 1'b0;
		end else begin
			core_clk_en <= in_normal && !waking_reg && !por_active;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_en <= 1'b1;
		end else begin
			osc_en <= !osc_stop;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_clk_en <= 1'b0;
		end else begin
			periph_clk_en <= !in_power_down;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tic_clk_en <= 1'b0;
		end else begin
			tic_clk_en <= !osc_stop;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_hold <= 1'b0;
		end else begin
			pins_hold <= !in_normal;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_out_oe <= 1'b0;
		end else begin
			dac_out_oe <= !in_power_down && !por_active;
		end
	end

	// Interrupt hand-off only once the core clock is back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_irq_take <= 1'b0;
		end else begin
			wake_irq_take <= in_normal && !waking_reg && !por_active
				&& |irq_pending && !irq_serviced;
		end
	end

	// APB: zero wait state; pready stands only in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	// Unmapped address answers error rather than aliasing a register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_phase && !addr_mapped;
		end
	end

	// Read data captured at setup so it stands beside pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			unique case (paddr)
				off_power_control: prdata <= power_control_view;
				off_clock_control: prdata <= clock_control_reg;
				off_status: prdata <= status_word;
				off_wake_cause: prdata <= {28'h0000000, wake_cause_reg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	logic unused_rd;
	assign unused_rd = rd_access;
endmodule : power_mode_wake_por_control

// File: tb/power_mode_wake_por_control_properties.sv
// Port-level checks for the power-mode, wake and power-on reset controller
`timescale 1ns/100ps
module power_mode_wake_por_control_properties #(
	parameter longint por_delay = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic supply_above_high,
	input wire logic supply_above_low,
	input wire logic pll_locked,
	input wire logic core_reset_n,
	input wire logic core_clk_en,
	input wire logic pll_en,
	input wire logic osc_en,
	input wire logic periph_clk_en,
	input wire logic tic_clk_en,
	input wire logic pins_hold,
	input wire logic dac_out_oe
);
	longint up_cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Supply-good run length, restarted by any dip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_cnt <= 0;
		end else begin
			up_cnt <= supply_above_high ? up_cnt + 1 : 0;
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_lock;
		##[1:40] pll_locked;
	endsequence
	AST_APB_ANSWER: assert property (s_setup |=> pready) else $error("no access answer");
	AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
	AST_POR_LOW: assert property (!supply_above_low |-> ##2 !core_reset_n) else $error("reset lost below low");
	AST_POR_TIMER: assert property ($rose(core_reset_n) |-> up_cnt >= por_delay - 1) else $error("early release");
	AST_PD_QUIET: assert property ((core_reset_n && !pll_en && pins_hold) [*2] |->
		!core_clk_en && !periph_clk_en && !dac_out_oe) else $error("power-down leak");
	AST_RELOCK: assert property ($rose(pll_en) && $past(core_reset_n) |-> !core_clk_en throughout s_lock)
		else $error("core clock before lock");
	AST_TIC_OSC: assert property (!osc_en |-> !tic_clk_en) else $error("interval clock without osc");
	AST_IDLE_OSC: assert property (core_reset_n && pll_en && pins_hold |-> osc_en) else $error("osc off in idle");
endmodule : power_mode_wake_por_control_properties
bind power_mode_wake_por_control power_mode_wake_por_control_properties #(.por_delay(por_delay))
	power_mode_wake_por_control_properties_i (.*);

// File: tb/core_pll_model.sv
// Core and PLL model beside the controller
`timescale 1ns/100ps
module core_pll_model (
	input wire logic pclk,
	input wire logic pll_en,
	input wire logic wake_irq_take,
	output logic pll_locked = 1'h0,
	output logic irq_serviced = 1'h0
);
	logic [2:0] lock_cnt = 3'h0;
	// Lock is lost at once when the PLL is stopped
	always @(posedge pclk) begin
		lock_cnt <= !pll_en ? 3'h0 : (lock_cnt == 3'h7 ? lock_cnt : lock_cnt + 3'h1);
		pll_locked <= pll_en && lock_cnt == 3'h7;
		irq_serviced <= wake_irq_take;
	end
endmodule : core_pll_model

// File: tb/power_mode_wake_por_control_tb_top.sv
// Self-checking bench for the power-mode, wake and power-on reset controller
`timescale 1ns/100ps
module power_mode_wake_por_control_tb_top;
	import pwr_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pslverr, pready, err;
	logic supply_above_high = 1'h1, supply_above_low = 1'h1, irq_serviced, pll_locked, core_reset_n, core_clk_en;
	logic pll_en, osc_en, periph_clk_en, tic_clk_en, pins_hold, dac_out_oe, wake_irq_take;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, pcw;
	wake_src_t irq_pending = '0;
	int n_errors = 0, n_compared = 0, n, src;
	always #4 pclk = ~pclk;
	power_mode_wake_por_control #(.por_delay(20)) power_mode_wake_por_control_i (.*);
	core_pll_model core_pll_model_i (.*);
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	function automatic logic woke(input int s, input logic [31:0] p);
		return s == 3 || (s == 2 && p[power_control_reg_serial_wake_bit]) || (s == 1 && p[power_control_reg_ext_int_wake_bit]);
	endfunction : woke
	task automatic end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		#200000;
		n_errors++;
		end_sim();
	end
	initial begin
		void'($urandom(32'h1c2c1743));
		repeat (6) @(posedge pclk);
		chk("reset outputs", {core_reset_n, osc_en, pll_en}, 3'h2);
		presetn <= 1'h1;
		for (n = 0; n < 99 && core_reset_n !== 1'h1; n++) @(posedge pclk);
		chk("por wait", n >= 20 && n <= 24, 1'h1);
		apb(1'h0, off_power_control, 0);
		chk("power control default", rd, power_control_reset);
		apb(1'h0, 12'h010, 0);
		chk("unmapped error", err, 1'h1);
		$display("Power-on test done");
		apb(1'h1, off_power_control, 32'h1);
		repeat (3) @(posedge pclk);
		chk("idle outputs", {core_clk_en, osc_en, periph_clk_en, pins_hold}, 4'h7);
		irq_pending.other <= 1'h1;
		for (n = 0; n < 99 && core_clk_en !== 1'h1; n++) @(posedge pclk);
		chk("idle wake", core_clk_en, 1'h1);
		irq_pending <= '0;
		$display("Idle test done");
		repeat (8) begin
			pcw = 32'h2 | ($urandom & 32'h1c);
			src = 1 + $urandom % 3;
			apb(1'h1, off_clock_control, pcw[4]);
			apb(1'h1, off_power_control, pcw & 32'hf);
			repeat (3) @(posedge pclk);
			chk("pd outputs", {pll_en, core_clk_en, osc_en, periph_clk_en, dac_out_oe, pins_hold, tic_clk_en, wake_irq_take},
				{2'h0, !pcw[4], 3'h1, !pcw[4], 1'h0});
			irq_pending[src] <= 1'h1;
			for (n = 0; n < 99 && core_clk_en !== 1'h1; n++) @(posedge pclk);
			chk("pd wake", core_clk_en, woke(src, pcw));
			irq_pending[3] <= 1'h1;
			for (n = 0; n < 99 && core_clk_en !== 1'h1; n++) @(posedge pclk);
			chk("relocked", pll_locked, 1'h1);
			repeat (4) @(posedge pclk);
			irq_pending <= '0;
			apb(1'h0, off_status, 0);
			chk("back to normal", rd[1:0], mode_normal);
			apb(1'h0, off_wake_cause, 0);
			chk("wake cause", rd, woke(src, pcw) ? 32'h1 << src : 32'h8 | 32'h1 << src);
			apb(1'h1, off_wake_cause, 32'hf);
		end
		$display("Power-down test done");
		apb(1'h1, off_power_control, 32'h2);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		for (n = 0; n < 99 && core_reset_n !== 1'h1; n++) @(posedge pclk);
		apb(1'h0, off_power_control, 0);
		chk("pd reset defaults", rd, power_control_reset);
		chk("normal after reset", core_clk_en, 1'h1);
		supply_above_low <= 1'h0;
		supply_above_high <= 1'h0;
		repeat (3) @(posedge pclk);
		chk("reset below low", core_reset_n, 1'h0);
		supply_above_low <= 1'h1;
		supply_above_high <= 1'h1;
		for (n = 0; n < 99 && core_reset_n !== 1'h1; n++) @(posedge pclk);
		chk("power cycle wait", n >= 20 && n <= 24, 1'h1);
		$display("Reset test done");
		end_sim();
	end
endmodule : power_mode_wake_por_control_tb_top
